/* File: shared/qmuthf_pkg.sv */
package qmuthf_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFS_RX_FRAME_THRESHOLD    = 12'h19C;
  localparam logic [ADDR_W-1:0] OFS_TX_NEXT_SPACE_REQUEST = 12'h19E;
  localparam logic [ADDR_W-1:0] OFS_GROUP_HASH_WORD0      = 12'h1A0;
  localparam logic [ADDR_W-1:0] OFS_GROUP_HASH_WORD1      = 12'h1A2;
  localparam logic [ADDR_W-1:0] OFS_GROUP_HASH_WORD2      = 12'h1A4;
  localparam logic [ADDR_W-1:0] OFS_GROUP_HASH_WORD3      = 12'h1A6;
  localparam int HASH_WORDS = 4;
  localparam int LIMIT_W = 8;
  localparam logic [LIMIT_W-1:0] RST_RX_COUNT_LIMIT = 8'h00;
  localparam logic [DATA_W-1:0] RST_TX_NEXT_SPACE   = 16'h0000;
  localparam logic [DATA_W-1:0] RST_GROUP_HASH      = 16'h0000;
  localparam logic [DATA_W-1:0] READ_UNMAPPED       = 16'h0000;
  localparam int DA_W = 48;
  localparam int DA_BYTES = 6;
  localparam int MCAST_BIT = 40;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam int HASH_IDX_W = 6;
  localparam int CRC_IDX_LSB = 26;
  localparam int WORD_SEL_LSB = 4;
endpackage

/* File: design/qmuthf_top.sv */
// Function
// - With the receive threshold enable set, the receive-ready flag is raised when the held frame count goes above the threshold.
// - The frame count threshold is an 8-bit read/write field in the low byte, reset to zero, with the upper byte reserved.
// - Software writes the next frame's transmit space need in double words into a 16-bit read/write register that resets to zero.
// - With the transmit space monitor set, the space-available flag is raised when free transmit space reaches the requested amount.
// - A 64-bit group hash table is indexed by the top six bits of a CRC over the 48-bit destination address.
// - The top two index bits pick one of four 16-bit hash words and the low four pick the bit.
// - The hash table filters group frames only in the hash-perfect filter mode.
// - A frame whose selected hash bit is set is accepted.
// - In hash-perfect mode a group frame with its hash bit clear is dropped unless receive-all and multicast-with-MAC are both set.
// - With receive-all and multicast-with-MAC both set, every multicast frame is accepted regardless of the table.
// - The receive-ready flag is edge triggered and cleared by a write of one.
`timescale 1ns/10ps
`default_nettype none
module qmuthf_top
  import qmuthf_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          srst,
  input  wire logic [qmuthf_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [1:0]                    reg_be,
  input  wire logic [qmuthf_pkg::DATA_W-1:0] reg_wdata,
  output logic      [qmuthf_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                          rx_thresh_en,
  input  wire logic                          rx_enabled,
  input  wire logic [7:0]                    rx_frame_count,
  input  wire logic                          rx_flag_clear,
  output logic                               rx_frame_ready_flag,
  input  wire logic                          tx_mem_monitor_en,
  input  wire logic [15:0]                   tx_free_dwords,
  input  wire logic                          tx_flag_clear,
  output logic                               tx_space_avail_flag,
  input  wire logic                          da_valid,
  input  wire logic [qmuthf_pkg::DA_W-1:0]   da_addr,
  input  wire logic                          hash_perfect_mode,
  input  wire logic                          rx_receive_all,
  input  wire logic                          rx_mcast_mac,
  output logic                               filt_valid,
  output logic                               filt_accept,
  output logic [qmuthf_pkg::HASH_IDX_W-1:0]  filt_index
);
  import qmuthf_pkg::*;

  logic [LIMIT_W-1:0] rx_count_limit;
  logic [DATA_W-1:0]  tx_next_space_request;
  logic [DATA_W-1:0]  group_hash_word [HASH_WORDS];
  logic               rx_cond_q;
  logic               tx_cond_q;

  // Address decode
  wire sel_thr  = (reg_addr == OFS_RX_FRAME_THRESHOLD);
  wire sel_txr  = (reg_addr == OFS_TX_NEXT_SPACE_REQUEST);
  wire [HASH_WORDS-1:0] sel_hash;
  assign sel_hash[0] = (reg_addr == OFS_GROUP_HASH_WORD0);
  assign sel_hash[1] = (reg_addr == OFS_GROUP_HASH_WORD1);
  assign sel_hash[2] = (reg_addr == OFS_GROUP_HASH_WORD2);
  assign sel_hash[3] = (reg_addr == OFS_GROUP_HASH_WORD3);

  wire wr_thr = reg_wr && sel_thr && reg_be[0];

  // Threshold low byte only; upper byte reserved, reads zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_count_limit <= RST_RX_COUNT_LIMIT;
    end else if (wr_thr) begin
      rx_count_limit <= reg_wdata[LIMIT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_next_space_request <= RST_TX_NEXT_SPACE;
    end else if (reg_wr && sel_txr) begin
      if (reg_be[0]) begin
        tx_next_space_request[7:0] <= reg_wdata[7:0];
      end
      if (reg_be[1]) begin
        tx_next_space_request[15:8] <= reg_wdata[15:8];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < HASH_WORDS; gi++) begin : g_hash
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          group_hash_word[gi] <= RST_GROUP_HASH;
        end else if (reg_wr && sel_hash[gi]) begin
          if (reg_be[0]) begin
            group_hash_word[gi][7:0] <= reg_wdata[7:0];
          end
          if (reg_be[1]) begin
            group_hash_word[gi][15:8] <= reg_wdata[15:8];
          end
        end
      end
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  wire [DATA_W-1:0] thr_read = {{(DATA_W-LIMIT_W){1'b0}}, rx_count_limit};
  wire [DATA_W-1:0] next_rdata =
    sel_thr     ? thr_read :
    sel_txr     ? tx_next_space_request :
    sel_hash[0] ? group_hash_word[0] :
    sel_hash[1] ? group_hash_word[1] :
    sel_hash[2] ? group_hash_word[2] :
    sel_hash[3] ? group_hash_word[3] : READ_UNMAPPED;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= READ_UNMAPPED;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Edge-triggered flags: a level that stays true does not re-raise
  wire rx_cond = rx_thresh_en && (rx_frame_count > rx_count_limit);
  wire rx_rise = rx_cond && !rx_cond_q;
  wire tx_cond = tx_mem_monitor_en &&
                 (tx_free_dwords >= tx_next_space_request);
  wire tx_rise = tx_cond && !tx_cond_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_cond_q <= 1'b0;
      tx_cond_q <= 1'b0;
    end else begin
      rx_cond_q <= rx_cond;
      tx_cond_q <= tx_cond;
    end
  end

  // Set wins over a clear in the same cycle, so no event is lost
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_frame_ready_flag <= 1'b0;
    end else if (rx_rise) begin
      rx_frame_ready_flag <= 1'b1;
    end else if (rx_flag_clear) begin
      rx_frame_ready_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_space_avail_flag <= 1'b0;
    end else if (tx_rise) begin
      tx_space_avail_flag <= 1'b1;
    end else if (tx_flag_clear) begin
      tx_space_avail_flag <= 1'b0;
    end
  end

  // Serial CRC unrolled over 48 bits; one cycle of logic depth
  function automatic logic [31:0] da_crc(input logic [DA_W-1:0] da);
    logic [31:0] c;
    logic        fb;
    c = CRC_INIT;
    fb = 1'b0;
    for (int b = 0; b < DA_BYTES; b++) begin
      for (int k = 0; k < 8; k++) begin
        fb = c[31] ^ da[DA_W-8-8*b+k];
        c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
      end
    end
    return c;
  endfunction

  wire [31:0]           crc_val   = da_crc(da_addr);
  wire [HASH_IDX_W-1:0] hash_idx  = crc_val[31:CRC_IDX_LSB];
  wire [1:0]            word_sel  = hash_idx[HASH_IDX_W-1:WORD_SEL_LSB];
  wire [3:0]            bit_sel   = hash_idx[WORD_SEL_LSB-1:0];
  wire [DATA_W-1:0]     hash_word = group_hash_word[word_sel];
  wire                  hash_hit  = hash_word[bit_sel];
  wire                  is_mcast  = da_addr[MCAST_BIT];
  wire                  mcast_all = rx_receive_all && rx_mcast_mac;
  // Table only judges group frames in hash-perfect mode
  wire                  use_hash  = hash_perfect_mode && is_mcast;
  wire next_accept = !use_hash || mcast_all || hash_hit;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      filt_valid  <= 1'b0;
      filt_accept <= 1'b0;
      filt_index  <= '0;
    end else begin
      filt_valid <= da_valid;
      if (da_valid) begin
        filt_accept <= next_accept;
        filt_index  <= hash_idx;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_rx_flag_set: assert property (rx_rise |=> rx_frame_ready_flag)
    else $error("rx ready flag not set on threshold crossing");
  a_rx_flag_clear: assert property
    (rx_frame_ready_flag && rx_flag_clear && !rx_rise |=> !rx_frame_ready_flag)
    else $error("rx ready flag not cleared");
  a_rx_flag_cause: assert property
    ($rose(rx_frame_ready_flag) |-> $past(rx_thresh_en)
       && ($past(rx_frame_count) > $past(rx_count_limit)))
    else $error("rx ready flag rose without cause");
  a_thr_write_read: assert property
    (wr_thr ##1 !reg_wr ##1 (reg_rd && sel_thr && !reg_wr)
       |=> reg_rdata == {8'h00, $past(reg_wdata[7:0], 3)})
    else $error("threshold readback wrong");
  a_thr_upper_zero: assert property
    ($past(reg_rd) && $past(sel_thr) |-> reg_rdata[15:8] == 8'h00)
    else $error("threshold upper byte not zero");
  a_txreq_hold: assert property
    (!(reg_wr && sel_txr) |=> $stable(tx_next_space_request))
    else $error("space request changed without write");
  a_tx_flag_set: assert property
    (tx_mem_monitor_en && tx_free_dwords >= tx_next_space_request
       && !tx_cond_q |=> tx_space_avail_flag)
    else $error("tx space flag not raised");
  a_tx_flag_cause: assert property
    ($rose(tx_space_avail_flag) |-> $past(tx_mem_monitor_en))
    else $error("tx space flag rose while monitor off");
  a_hash_drop: assert property
    (da_valid && hash_perfect_mode && is_mcast && !mcast_all
       && !group_hash_word[hash_idx[5:4]][hash_idx[3:0]]
       |=> filt_valid && !filt_accept)
    else $error("frame with clear hash bit not dropped");
  a_hash_accept: assert property
    (da_valid && group_hash_word[hash_idx[5:4]][hash_idx[3:0]]
       |=> filt_accept && filt_index == $past(hash_idx))
    else $error("frame with set hash bit not accepted");
  a_mcast_all: assert property
    (da_valid && rx_receive_all && rx_mcast_mac |=> filt_accept)
    else $error("receive-all multicast frame dropped");
  a_non_hash_pass: assert property
    (da_valid && !hash_perfect_mode |=> filt_accept)
    else $error("frame filtered outside hash mode");
  a_unicast_pass: assert property
    (da_valid && !is_mcast |=> filt_accept)
    else $error("individual address frame filtered");
  a_filt_valid: assert property
    (da_valid |=> filt_valid)
    else $error("filter verdict missing");
  a_filt_pulse: assert property
    (!da_valid |=> !filt_valid)
    else $error("filter verdict without address");
  // Verdict must hold for a reader that polls late
  a_filt_hold: assert property
    (!da_valid |=> $stable(filt_accept) && $stable(filt_index))
    else $error("filter verdict changed without address");

  // Flags hold until cleared; set beats clear so no event is lost
  a_rx_flag_keep: assert property
    (rx_frame_ready_flag && !rx_flag_clear |=> rx_frame_ready_flag)
    else $error("rx ready flag dropped without clear");
  a_rx_set_wins: assert property
    (rx_rise && rx_flag_clear |=> rx_frame_ready_flag)
    else $error("rx ready flag lost to a clear");
  a_tx_flag_clear: assert property
    (tx_space_avail_flag && tx_flag_clear && !tx_rise
       |=> !tx_space_avail_flag)
    else $error("tx space flag not cleared");
  a_tx_flag_keep: assert property
    (tx_space_avail_flag && !tx_flag_clear |=> tx_space_avail_flag)
    else $error("tx space flag dropped without clear");
  a_tx_set_wins: assert property
    (tx_rise && tx_flag_clear |=> tx_space_avail_flag)
    else $error("tx space flag lost to a clear");

  // Register file: full-enable writes land whole, reads hold until the next strobe
  a_thr_hold: assert property
    (!wr_thr |=> $stable(rx_count_limit))
    else $error("threshold changed without write");
  a_txreq_write: assert property
    (reg_wr && sel_txr && reg_be == 2'h3
       |=> tx_next_space_request == $past(reg_wdata))
    else $error("space request write lost");
  a_rdata_hold: assert property
    (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  // Holes in the map read zero so software can probe safely
  a_unmapped_zero: assert property
    (reg_rd && !(sel_thr || sel_txr || (|sel_hash))
       |=> reg_rdata == READ_UNMAPPED)
    else $error("unmapped read not zero");

  // Explicit clock: the loop scope does not lean on the default
  for (genvar gj = 0; gj < HASH_WORDS; gj++) begin : g_hash_chk
    a_hash_hold: assert property
      (@(posedge ref_clk) disable iff (srst)
         !(reg_wr && sel_hash[gj]) |=> $stable(group_hash_word[gj]))
      else $error("hash word changed without write");
  end

  c_rx_flag: cover property (rx_rise ##[1:4] rx_flag_clear);
  c_tx_flag: cover property (tx_rise ##1 tx_space_avail_flag);
  c_hash_drop: cover property (filt_valid && !filt_accept);
  c_set_clear: cover property (rx_rise && rx_flag_clear);
  // Threshold writes during reception are legal except a value of one
  c_thr_live: cover property (rx_enabled && wr_thr);
endmodule
`default_nettype wire

/* File: tb/qmuthf_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module qmuthf_host_model
  import qmuthf_pkg::*;
(
  input  wire logic                          ref_clk,
  output logic      [qmuthf_pkg::ADDR_W-1:0] reg_addr,
  output logic                               reg_wr,
  output logic                               reg_rd,
  output logic      [1:0]                    reg_be,
  output logic      [qmuthf_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic [qmuthf_pkg::DATA_W-1:0] reg_rdata
);
  initial begin
    reg_addr = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_be = 2'h0;
    reg_wdata = '0;
  end
  // Thresholds below two are never sent, whatever the receive state
  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    input logic [1:0] be);
    if (a == OFS_RX_FRAME_THRESHOLD && d[7:0] < 8'h02) return;
    @(posedge ref_clk);
    reg_addr <= a;
    reg_be <= be;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import qmuthf_pkg::*;
  logic        ref_clk, srst, reg_wr, reg_rd, rx_thresh_en, rx_enabled;
  logic        rx_flag_clear, rx_frame_ready_flag, tx_mem_monitor_en;
  logic        tx_flag_clear, tx_space_avail_flag, da_valid, filt_valid;
  logic        hash_perfect_mode, rx_receive_all, rx_mcast_mac, filt_accept;
  logic [1:0]  reg_be;
  logic [5:0]  filt_index;
  logic [7:0]  rx_frame_count;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, tx_free_dwords, v;
  logic [15:0] ht [4];
  logic [47:0] da_addr;
  int          fails, total_checks;
  qmuthf_top u_qmuthf_top (.ref_clk, .srst, .reg_addr, .reg_wr, .reg_rd,
    .reg_be, .reg_wdata, .reg_rdata, .rx_thresh_en, .rx_enabled,
    .rx_frame_count, .rx_flag_clear, .rx_frame_ready_flag,
    .tx_mem_monitor_en, .tx_free_dwords, .tx_flag_clear,
    .tx_space_avail_flag, .da_valid, .da_addr, .hash_perfect_mode,
    .rx_receive_all, .rx_mcast_mac, .filt_valid, .filt_accept, .filt_index);
  qmuthf_host_model u_qmuthf_host_model (.ref_clk, .reg_addr, .reg_wr,
    .reg_rd, .reg_be, .reg_wdata, .reg_rdata);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Own CRC walk so the index is not taken from the design
  function automatic logic [5:0] hidx(input logic [47:0] a);
    logic [31:0] c;
    logic        fb;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < 48; i++) begin
      fb = c[31] ^ a[40 - 8 * (i / 8) + i % 8];
      c = {c[30:0], 1'b0} ^ (fb ? 32'h04C11DB7 : 32'h00000000);
    end
    return c[31:26];
  endfunction
  task automatic hw(input int i, input logic [15:0] d);
    u_qmuthf_host_model.wr(OFS_GROUP_HASH_WORD0 + 12'(2 * i), d, 2'h3);
    ht[i] = d;
  endtask
  task automatic filt(input logic [47:0] a);
    logic [5:0] x;
    logic       e;
    x = hidx(a);
    @(posedge ref_clk);
    e = !(hash_perfect_mode && a[40]) || (rx_receive_all && rx_mcast_mac)
        || ht[x[5:4]][x[3:0]];
    da_valid <= 1'b1;
    da_addr <= a;
    @(posedge ref_clk);
    da_valid <= 1'b0;
    da_addr <= ~a;
    @(posedge ref_clk);
    chk(16'(filt_valid), 16'h0001);
    chk(16'(filt_index), 16'(x));
    chk(16'(filt_accept), 16'(e));
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    conclude();
  end
  initial begin
    logic [47:0] adr [4];
    logic [5:0]  x;
    adr = '{48'h01005E0000FB, 48'h333300000001, 48'h0180C2000000,
            48'h001122334455};
    {srst, rx_thresh_en, rx_enabled, rx_flag_clear, tx_mem_monitor_en} = 5'h14;
    {tx_flag_clear, da_valid, hash_perfect_mode} = 3'h0;
    {rx_receive_all, rx_mcast_mac, rx_frame_count, tx_free_dwords} = '0;
    da_addr = '0;
    step(5);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      u_qmuthf_host_model.rd(OFS_RX_FRAME_THRESHOLD + 12'(2 * i), v);
      chk(v, 16'h0000);
    end
    u_qmuthf_host_model.wr(OFS_RX_FRAME_THRESHOLD, 16'hFF05, 2'h3);
    u_qmuthf_host_model.rd(OFS_RX_FRAME_THRESHOLD, v);
    chk(v, 16'h0005);
    u_qmuthf_host_model.wr(OFS_RX_FRAME_THRESHOLD, 16'h0009, 2'h2);
    u_qmuthf_host_model.rd(OFS_RX_FRAME_THRESHOLD, v);
    chk(v, 16'h0005);
    u_qmuthf_host_model.wr(OFS_TX_NEXT_SPACE_REQUEST, 16'hA55A, 2'h3);
    u_qmuthf_host_model.wr(12'h1A8, 16'hFFFF, 2'h3);
    u_qmuthf_host_model.rd(12'h1A8, v);
    chk(v, 16'h0000);
    u_qmuthf_host_model.rd(OFS_TX_NEXT_SPACE_REQUEST, v);
    chk(v, 16'hA55A);
    for (int i = 0; i < 4; i++) hw(i, 16'h1111 << i);
    for (int i = 0; i < 4; i++) begin
      u_qmuthf_host_model.rd(OFS_GROUP_HASH_WORD0 + 12'(2 * i), v);
      chk(v, 16'h1111 << i);
    end
    $display("Test registers done");
    rx_thresh_en <= 1'b1;
    rx_frame_count <= 8'h05;
    step(3);
    chk(16'(rx_frame_ready_flag), 16'h0000);
    rx_frame_count <= 8'h06;
    step(1);
    chk(16'(rx_frame_ready_flag), 16'h0000);
    step(1);
    chk(16'(rx_frame_ready_flag), 16'h0001);
    rx_flag_clear <= 1'b1;
    step(1);
    rx_flag_clear <= 1'b0;
    step(4);
    chk(16'(rx_frame_ready_flag), 16'h0000);
    rx_thresh_en <= 1'b0;
    rx_frame_count <= 8'h00;
    step(2);
    rx_frame_count <= 8'h09;
    step(3);
    chk(16'(rx_frame_ready_flag), 16'h0000);
    rx_thresh_en <= 1'b1;
    rx_flag_clear <= 1'b1;
    step(1);
    rx_flag_clear <= 1'b0;
    step(1);
    chk(16'(rx_frame_ready_flag), 16'h0001);
    u_qmuthf_host_model.wr(OFS_TX_NEXT_SPACE_REQUEST, 16'h0010, 2'h3);
    tx_mem_monitor_en <= 1'b1;
    tx_free_dwords <= 16'h000F;
    step(3);
    chk(16'(tx_space_avail_flag), 16'h0000);
    tx_free_dwords <= 16'h0010;
    step(2);
    chk(16'(tx_space_avail_flag), 16'h0001);
    tx_flag_clear <= 1'b1;
    step(1);
    tx_flag_clear <= 1'b0;
    step(2);
    chk(16'(tx_space_avail_flag), 16'h0000);
    tx_free_dwords <= 16'h000F;
    step(2);
    tx_free_dwords <= 16'h0011;
    step(2);
    chk(16'(tx_space_avail_flag), 16'h0001);
    $display("Test flags done");
    x = hidx(adr[0]);
    hw(int'(x[5:4]), ht[x[5:4]] | (16'h0001 << x[3:0]));
    for (int m = 0; m < 8; m++) begin
      {hash_perfect_mode, rx_receive_all, rx_mcast_mac} <= 3'(m);
      for (int k = 0; k < 4; k++) filt(adr[k]);
    end
    hw(int'(x[5:4]), 16'h0000);
    {hash_perfect_mode, rx_receive_all, rx_mcast_mac} <= 3'h4;
    filt(adr[0]);
    $display("Test filter done");
    srst <= 1'b1;
    step(2);
    srst <= 1'b0;
    u_qmuthf_host_model.rd(OFS_RX_FRAME_THRESHOLD, v);
    chk(v, 16'h0000);
    u_qmuthf_host_model.rd(OFS_TX_NEXT_SPACE_REQUEST, v);
    chk(v, 16'h0000);
    $display("Test reset done");
    conclude();
  end
endmodule
`default_nettype wire
